// [hdl/deac_regs.svh]
// Register offsets, field positions, unlock keys and timing counts
`ifndef DEAC_REGS_SVH
`define DEAC_REGS_SVH

`define DEAC_OFS_CTRL      12'hfa6
`define DEAC_OFS_KEY       12'hfa7
`define DEAC_OFS_BUF       12'hfa8
`define DEAC_OFS_LOC_LOW   12'hfa9
`define DEAC_OFS_LOC_HIGH  12'hfaa
`define DEAC_OFS_FLAGS     12'hfab
`define DEAC_OFS_STATUS    12'hfac

`define DEAC_BIT_MEMSEL    7
`define DEAC_BIT_CFGSEL    6
`define DEAC_BIT_ROWERASE  4
`define DEAC_BIT_WRITE_ERROR_FLAG     3
`define DEAC_BIT_WRITE_ENABLE_GATE      2
`define DEAC_BIT_WRTRIG    1
`define DEAC_BIT_RDTRIG    0
`define DEAC_BIT_DONE      0

`define DEAC_KEY_FIRST     8'h55
`define DEAC_KEY_SECOND    8'haa
`define DEAC_DEPTH         1024

`define DEAC_CLK_HZ        20000000
`define DEAC_PWRUP_MS      72
`define DEAC_PWRUP_CYCLES  ((`DEAC_CLK_HZ / 1000) * `DEAC_PWRUP_MS)
`define DEAC_WRITE_CYCLES  200

`endif

// [hdl/deac_pkg.sv]
// Types for the data array access controller
package deac_pkg;
  typedef enum logic [1:0] {
    DEAC_UNLOCK_IDLE  = 2'b00,
    DEAC_UNLOCK_FIRST = 2'b01,
    DEAC_UNLOCK_ARMED = 2'b10
  } deac_unlock_type;
endpackage : deac_pkg

// [hdl/deac_controller.sv]
// Data array access controller: registers, unlock, self-timed write
// ============================================================
//
// The implementer's own choice: the address-and-strobe port.
`include "deac_regs.svh"

module deac_controller
  import deac_pkg::*;
#(
  parameter int PWRUP_CYCLES = `DEAC_PWRUP_CYCLES,
  parameter int WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Reset causes that abort a write, from pins
  input  wire logic        pinResetEvent,
  input  wire logic        watchdogTimeout,
  // Register port
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  // Status
  output logic             writeBusy,
  output logic             completionFlag
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rstSync;
  logic       rstLocal_b;
  logic [1:0] abortPin;
  logic [1:0] abortSync;
  logic       abortEvent;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstLocal_b = rstSync[1];

  // Both abort causes come from pins
  assign abortPin = {watchdogTimeout, pinResetEvent};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_abort_sync
      logic [1:0] syncStage;

      always_ff @(posedge clk_sys or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
          syncStage <= 2'b00;
        end else begin
          syncStage <= {syncStage[0], abortPin[i]};
        end
      end
      assign abortSync[i] = syncStage[1];
    end
  endgenerate
  assign abortEvent = |abortSync;

  // ==========================================================
  // Registers
  logic [7:0]      memory [0:`DEAC_DEPTH-1];
  logic [7:0]      byteBuffer;
  logic [7:0]      locationLow;
  logic [1:0]      locationHigh;
  logic [9:0]      location;
  logic            memorySelect;
  logic            configurationSelect;
  logic            rowEraseEnable;
  logic            writeErrorFlag;
  logic            writeEnableGate;
  logic            writeTrigger;
  logic            readTrigger;
  deac_unlock_type unlockState;
  deac_unlock_type next_unlockState;
  logic [31:0]     writeCount;
  logic [31:0]     pwrupCount;
  logic            pwrupDone;
  logic            ctrlWrite;
  logic            keyWrite;
  logic            startWrite;
  logic            startRead;
  logic            writeDone;
  logic            writeAbort;
  logic            selCtrl;
  logic            selKey;
  logic            selBuf;
  logic            selLocLow;
  logic            selLocHigh;
  logic            selFlags;
  logic            selStatus;
  logic            flagClear;
  logic [7:0]      ctrlReadValue;
  logic [7:0]      next_regRdData;

  // Address decode
  assign selCtrl    = regAddr == `DEAC_OFS_CTRL;
  assign selKey     = regAddr == `DEAC_OFS_KEY;
  assign selBuf     = regAddr == `DEAC_OFS_BUF;
  assign selLocLow  = regAddr == `DEAC_OFS_LOC_LOW;
  assign selLocHigh = regAddr == `DEAC_OFS_LOC_HIGH;
  assign selFlags   = regAddr == `DEAC_OFS_FLAGS;
  assign selStatus  = regAddr == `DEAC_OFS_STATUS;

  assign location  = {locationHigh, locationLow};
  assign ctrlWrite = regWrite && selCtrl && !writeTrigger;
  assign keyWrite  = regWrite && selKey;
  assign flagClear = regWrite && selFlags && !regWrData[`DEAC_BIT_DONE];
  // Trigger counts only when enable was already set before this write
  assign startWrite = ctrlWrite && regWrData[`DEAC_BIT_WRTRIG]
                      && writeEnableGate
                      && unlockState == DEAC_UNLOCK_ARMED
                      && pwrupDone;
  assign startRead = ctrlWrite && regWrData[`DEAC_BIT_RDTRIG]
                     && !regWrData[`DEAC_BIT_MEMSEL]
                     && !memorySelect;
  assign writeDone = writeTrigger && writeCount == 32'(WRITE_CYCLES - 1);
  assign writeAbort = abortEvent && writeTrigger;

  // ==========================================================
  // Power-up write lockout
  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      pwrupCount <= 32'h0;
    end else if (!pwrupDone) begin
      pwrupCount <= pwrupCount + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      pwrupDone <= 1'b0;
    end else if (!pwrupDone) begin
      pwrupDone <= pwrupCount == 32'(PWRUP_CYCLES - 1);
    end
  end

  // ==========================================================
  // Unlock sequence tracker
  always_comb begin
    next_unlockState = unlockState;
    if (regWrite) begin
      case (unlockState)
        DEAC_UNLOCK_IDLE: begin
          if (keyWrite && regWrData == `DEAC_KEY_FIRST) begin
            next_unlockState = DEAC_UNLOCK_FIRST;
          end else begin
            next_unlockState = DEAC_UNLOCK_IDLE;
          end
        end
        DEAC_UNLOCK_FIRST: begin
          if (keyWrite && regWrData == `DEAC_KEY_SECOND) begin
            next_unlockState = DEAC_UNLOCK_ARMED;
          end else begin
            next_unlockState = DEAC_UNLOCK_IDLE;
          end
        end
        DEAC_UNLOCK_ARMED: begin
          next_unlockState = DEAC_UNLOCK_IDLE;
        end
        default: begin
          next_unlockState = DEAC_UNLOCK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      unlockState <= DEAC_UNLOCK_IDLE;
    end else begin
      unlockState <= next_unlockState;
    end
  end

  // ==========================================================
  // Access control bits
  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      memorySelect        <= 1'b0;
      configurationSelect <= 1'b0;
      writeEnableGate     <= 1'b0;
    end else if (ctrlWrite) begin
      memorySelect        <= regWrData[`DEAC_BIT_MEMSEL];
      configurationSelect <= regWrData[`DEAC_BIT_CFGSEL];
      writeEnableGate     <= regWrData[`DEAC_BIT_WRITE_ENABLE_GATE];
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      readTrigger <= 1'b0;
    end else begin
      readTrigger <= startRead;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      rowEraseEnable <= 1'b0;
    end else if (ctrlWrite && !startWrite) begin
      rowEraseEnable <= regWrData[`DEAC_BIT_ROWERASE];
    end else if (writeDone && !abortEvent) begin
      rowEraseEnable <= 1'b0;
    end
  end

  // ==========================================================
  // Self-timed write and error flag
  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      writeTrigger <= 1'b0;
    end else if (writeAbort) begin
      writeTrigger <= 1'b0;
    end else if (startWrite) begin
      writeTrigger <= 1'b1;
    end else if (writeDone) begin
      writeTrigger <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      writeCount <= 32'h0;
    end else if (startWrite) begin
      writeCount <= 32'h0;
    end else if (writeTrigger && !writeDone && !abortEvent) begin
      writeCount <= writeCount + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      writeErrorFlag <= 1'b0;
    end else if (writeAbort) begin
      writeErrorFlag <= 1'b1;
    end else if (startWrite) begin
      writeErrorFlag <= 1'b0;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      completionFlag <= 1'b0;
    end else if (writeDone && !abortEvent) begin
      completionFlag <= 1'b1;
    end else if (flagClear) begin
      completionFlag <= 1'b0;
    end
  end
  assign writeBusy = writeTrigger;

  // ==========================================================
  // Array, buffer and location registers
  always_ff @(posedge clk_sys) begin
    if (writeDone && !abortEvent && !memorySelect
        && !configurationSelect) begin
      memory[location] <= byteBuffer;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      byteBuffer <= 8'h00;
    end else if (writeAbort) begin
      byteBuffer <= 8'h00;
    end else if (readTrigger && !configurationSelect) begin
      byteBuffer <= memory[location];
    end else if (regWrite && !writeTrigger && selBuf) begin
      byteBuffer <= regWrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      locationLow <= 8'h00;
    end else if (writeAbort) begin
      locationLow <= 8'h00;
    end else if (regWrite && !writeTrigger && selLocLow) begin
      locationLow <= regWrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      locationHigh <= 2'b00;
    end else if (regWrite && !writeTrigger && selLocHigh) begin
      locationHigh <= regWrData[1:0];
    end
  end

  // ==========================================================
  // Read data
  assign ctrlReadValue = {memorySelect, configurationSelect, 1'b0,
                          rowEraseEnable, writeErrorFlag, writeEnableGate,
                          writeTrigger, readTrigger};

  always_comb begin
    next_regRdData = 8'h00;
    if (!regRead) begin
      next_regRdData = 8'h00;
    end else if (selCtrl) begin
      next_regRdData = ctrlReadValue;
    end else if (selKey) begin
      next_regRdData = 8'h00;
    end else if (selBuf) begin
      next_regRdData = byteBuffer;
    end else if (selLocLow) begin
      next_regRdData = locationLow;
    end else if (selLocHigh) begin
      next_regRdData = {6'b000000, locationHigh};
    end else if (selFlags) begin
      next_regRdData = {7'b0000000, completionFlag};
    end else if (selStatus) begin
      next_regRdData = {7'b0000000, pwrupDone};
    end else begin
      next_regRdData = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule : deac_controller

// [sim/deac_controller_chk.sv]
// Port checker for the data array access controller
`include "deac_regs.svh"
// ====================================================
// Checker
module deac_controller_chk #(
  parameter int PWRUP_CYCLES = 20,
  parameter int WRITE_CYCLES = 8
) (
  // Clock, reset and abort causes
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        pinResetEvent,
  input wire logic        watchdogTimeout,
  // Register port and status
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdData,
  input wire logic        writeBusy,
  input wire logic        completionFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  int   upCnt;
  int   busyCnt;
  logic keyOne;
  logic keyTwo;
  logic abortSeen;
  wire  keyW = regWrite && regAddr == `DEAC_OFS_KEY;
  wire  trigOk = regWrite && regAddr == `DEAC_OFS_CTRL && regWrData[1]
                 && keyTwo;
  wire  flagClr = regWrite && regAddr == `DEAC_OFS_FLAGS && !regWrData[0];
  // Lockout, write length and abort tracking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upCnt     <= 0;
      busyCnt   <= 0;
      abortSeen <= 1'b0;
    end else begin
      upCnt     <= (upCnt < PWRUP_CYCLES) ? upCnt + 1 : upCnt;
      busyCnt   <= writeBusy ? busyCnt + 1 : 0;
      abortSeen <= writeBusy && (abortSeen || pinResetEvent
                   || watchdogTimeout);
    end
  end
  // Unlock key tracking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      keyOne <= 1'b0;
      keyTwo <= 1'b0;
    end else if (regWrite) begin
      keyOne <= keyW && regWrData == `DEAC_KEY_FIRST;
      keyTwo <= keyOne && keyW && regWrData == `DEAC_KEY_SECOND;
    end
  end
  // ==================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_end;
    $fell(writeBusy) ##0 !abortSeen;
  endsequence
  property p_start_keys; $rose(writeBusy) |-> $past(trigOk); endproperty
  a_start_keys: assert property (p_start_keys)
    else $error("write started without unlock sequence");
  property p_pwrup; $rose(writeBusy) |-> upCnt >= PWRUP_CYCLES; endproperty
  a_pwrup: assert property (p_pwrup)
    else $error("write started during power-up lockout");
  property p_busy_len; s_end |-> busyCnt == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write length wrong");
  property p_done; s_end |-> completionFlag; endproperty
  a_done: assert property (p_done)
    else $error("completion flag not set at write end");
  property p_flag_hold; completionFlag && !flagClr |=> completionFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("completion flag dropped without clear");
  property p_key_zero;
    regRead && regAddr == `DEAC_OFS_KEY |=> regRdData == 8'h00;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key port read not zero");
  property p_hi_zero;
    regRead && regAddr == `DEAC_OFS_LOC_HIGH |=> regRdData[7:2] == 6'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("high location upper bits not zero");
  property p_rd_idle; !regRead |=> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule : deac_controller_chk

bind deac_controller deac_controller_chk #(
  .PWRUP_CYCLES(PWRUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .pinResetEvent(pinResetEvent),
  .watchdogTimeout(watchdogTimeout), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .writeBusy(writeBusy),
  .completionFlag(completionFlag)
);

// [sim/deac_controller_tb.sv]
// Self-checking bench for the data array access controller
`include "deac_regs.svh"
// ====================================================
// Bench
module deac_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 20;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        pinResetEvent = 1'b0;
  logic        watchdogTimeout = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdData;
  logic        writeBusy;
  logic        completionFlag;
  logic [7:0]  mem [logic [9:0]];
  int          errors = 0;
  int          checked = 0;

  deac_controller #(.PWRUP_CYCLES(PW), .WRITE_CYCLES(8)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .pinResetEvent(pinResetEvent),
    .watchdogTimeout(watchdogTimeout), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .writeBusy(writeBusy),
    .completionFlag(completionFlag)
  );

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // ==================================================
  // Tasks
  function automatic logic [7:0] hiExp(logic [9:0] a);
    return {6'h00, a[9:8]};
  endfunction : hiExp
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk_sys);
    regWrite  <= 1'b0;
  endtask : wr
  task automatic rchk(string n, logic [11:0] a, logic [7:0] m, e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(n, e, regRdData & m);
  endtask : rchk
  task automatic go(logic [7:0] k, c, logic s, m);
    wr(`DEAC_OFS_KEY, k);
    if (m) begin
      wr(`DEAC_OFS_BUF, 8'h00);
    end
    wr(`DEAC_OFS_KEY, `DEAC_KEY_SECOND);
    wr(`DEAC_OFS_CTRL, c);
    @(posedge clk_sys);
    #1 chk("busy", {7'h00, s}, {7'h00, writeBusy});
  endtask : go
  task automatic idle();
    for (int i = 0; i < 40 && writeBusy !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    #1 chk("idle", 8'h00, {7'h00, writeBusy});
  endtask : idle
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #(50 * 4000);
    errors++;
    final_report();
  end
  // ==================================================
  // Scenarios
  initial begin
    logic [9:0] a;
    logic [7:0] d;
    void'($urandom(32'had3cc5bc));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk("ctrl", `DEAC_OFS_CTRL, 8'h27, 8'h00);
    wr(`DEAC_OFS_CTRL, 8'h04);
    go(`DEAC_KEY_FIRST, 8'h06, 1'b0, 1'b0);
    repeat (PW + 5) @(posedge clk_sys);
    rchk("key", `DEAC_OFS_KEY, 8'hff, 8'h00);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 10'h3ff : 10'($urandom);
      d = 8'($urandom);
      wr(`DEAC_OFS_LOC_HIGH, {6'($urandom), a[9:8]});
      rchk("high", `DEAC_OFS_LOC_HIGH, 8'hff, hiExp(a));
      wr(`DEAC_OFS_LOC_LOW, a[7:0]);
      wr(`DEAC_OFS_BUF, d);
      go(`DEAC_KEY_FIRST, 8'h06, 1'b1, 1'b0);
      wr(`DEAC_OFS_CTRL, 8'h00);
      wr(`DEAC_OFS_BUF, ~d);
      wr(`DEAC_OFS_LOC_LOW, ~a[7:0]);
      idle();
      chk("done", 8'h01, {7'h00, completionFlag});
      rchk("ctrl", `DEAC_OFS_CTRL, 8'h06, 8'h04);
      rchk("buf", `DEAC_OFS_BUF, 8'hff, d);
      rchk("low", `DEAC_OFS_LOC_LOW, 8'hff, a[7:0]);
      wr(`DEAC_OFS_FLAGS, 8'h00);
      rchk("flag", `DEAC_OFS_FLAGS, 8'h01, 8'h00);
      mem[a] = d;
    end
    foreach (mem[k]) begin
      wr(`DEAC_OFS_LOC_HIGH, hiExp(k));
      wr(`DEAC_OFS_LOC_LOW, k[7:0]);
      wr(`DEAC_OFS_CTRL, 8'h01);
      rchk("rd", `DEAC_OFS_BUF, 8'hff, mem[k]);
    end
    wr(`DEAC_OFS_CTRL, 8'h00);
    go(`DEAC_KEY_FIRST, 8'h02, 1'b0, 1'b0);
    go(`DEAC_KEY_FIRST, 8'h06, 1'b0, 1'b0);
    go(8'h56, 8'h06, 1'b0, 1'b0);
    go(`DEAC_KEY_FIRST, 8'h06, 1'b0, 1'b1);
    wr(`DEAC_OFS_BUF, 8'h5a);
    wr(`DEAC_OFS_CTRL, 8'h80);
    wr(`DEAC_OFS_CTRL, 8'h81);
    rchk("memsel", `DEAC_OFS_BUF, 8'hff, 8'h5a);
    for (int s = 0; s < 2; s++) begin
      wr(`DEAC_OFS_LOC_LOW, 8'h3c);
      wr(`DEAC_OFS_BUF, 8'hc3);
      wr(`DEAC_OFS_CTRL, 8'h14);
      go(`DEAC_KEY_FIRST, 8'h16, 1'b1, 1'b0);
      @(posedge clk_sys);
      pinResetEvent   <= (s == 0);
      watchdogTimeout <= (s == 1);
      idle();
      @(posedge clk_sys);
      pinResetEvent   <= 1'b0;
      watchdogTimeout <= 1'b0;
      rchk("err", `DEAC_OFS_CTRL, 8'h98, 8'h18);
      rchk("buf0", `DEAC_OFS_BUF, 8'hff, 8'h00);
      rchk("low0", `DEAC_OFS_LOC_LOW, 8'hff, 8'h00);
    end
    final_report();
  end
endmodule : deac_controller_tb
